// *** design/cld_char_lcd_decoder.sv ***
// Purpose: instruction decoder and executor of a character display
// Assumes: host bus pins are synchronous to SYS_CLK; transfer on E fall
// Notes:   transfers other than status reads are ignored while busy
// Operation
// - each accepted byte takes effect at once, its busy time counted on the internal clock, the all-zero instruction excepted
// - address counter steps by one after every RAM access
// - busy flag reads high on data line 7 during execution
// - status read returns busy flag and 7-bit address, adds no time
// - clear fills display RAM with spaces, address zero, increment mode
// - return home zeroes address and undoes display shift
// - entry mode stores step direction and auto shift
// - direction high steps address up, low steps it down
// - glyph RAM accesses step the address the same way
// - auto shift moves the display only on display RAM writes, not on reads or glyph writes
// - display control loads display, cursor and blink enables
// - shift instruction uses target and direction bits, RAM untouched
// - function set loads bus width, line count and font size
// - glyph address set loads six bits and selects glyph RAM
// - display address set loads seven bits and selects display RAM
// - data write stores the byte in the selected RAM
// - data read returns the byte of the selected RAM
// - 4-bit width moves each byte as two upper-line nibbles
// - display off blanks the character output but keeps RAM contents
// - cursor shift steps address, display shift moves the window
`timescale 1ns/1ps
module cld_char_lcd_decoder import cld_pkg::*; #(
  parameter int OSC_DIV = CLD_OSC_DIV
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // host parallel bus
  input wire logic REG_SELECT,
  input wire logic READ_WRITE_SEL,
  input wire logic ENABLE,
  input wire logic [7:0] DB_IN,
  output logic [7:0] DB_OUT,
  output logic DB_OE,
  // execution status
  output logic BUSY_FLAG,
  output logic [6:0] ADDR_COUNTER,
  output logic GLYPH_SEL,
  // mode bits
  output logic INCR_DECR,
  output logic AUTO_SHIFT,
  output logic DISPLAY_ON,
  output logic CURSOR_ON,
  output logic BLINK_ON,
  output logic BUS_WIDTH,
  output logic LINE_COUNT,
  output logic FONT_SIZE,
  output logic [6:0] DISP_SHIFT,
  // pixel drive side
  input wire logic [6:0] DISP_COL,
  output logic [7:0] DISP_CHAR,
  input wire logic [5:0] GLYPH_ADDR,
  output logic [7:0] GLYPH_ROW
);
  typedef struct packed {
    logic e_d;
    cld_nib_e nib;
    logic [3:0] hi_nib;
    logic [6:0] ac;
    logic cg_sel;
    logic incr_decr;
    logic auto_shift;
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width;
    logic line_count;
    logic font_size;
    logic [6:0] shift_off;
    logic clearing;
    logic [6:0] clr_idx;
    logic [7:0] dout;
    logic [7:0] disp_char;
    logic [7:0] glyph_row;
  } cld_state_s;

  cld_state_s r_ff;
  cld_state_s nxt_r;

  logic busy;
  logic fall;
  logic xfer_done;
  logic status_rd;
  logic accept;
  logic acc_wr;
  logic acc_rd;
  logic acc_cmd;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic [7:0] dd_rdata;
  logic [7:0] cg_rdata;
  logic [7:0] dd_view;
  logic [7:0] cg_view;
  logic [6:0] ac_step;
  logic [6:0] ac_back;
  logic [6:0] ac_fwd;
  logic [6:0] view_addr;
  logic dd_we;
  logic cg_we;
  logic [6:0] dd_waddr;
  logic [7:0] dd_wdata;
  logic tmr_start;
  logic [8:0] tmr_ticks;
  cld_op_e op;

  // a transfer is taken on the falling edge of the enable strobe
  assign fall = r_ff.e_d & ~ENABLE;
  // in 4-bit mode only the second nibble completes a byte
  assign xfer_done = fall & (r_ff.bus_width | r_ff.nib == CLD_NIB_LO);
  assign byte_in = r_ff.bus_width ? DB_IN
                                  : {r_ff.hi_nib, DB_IN[7:4]};
  assign status_rd = ~REG_SELECT & READ_WRITE_SEL;
  assign accept = xfer_done & ~status_rd & ~busy;
  assign acc_wr = accept & REG_SELECT & ~READ_WRITE_SEL;
  assign acc_rd = accept & REG_SELECT & READ_WRITE_SEL;
  assign acc_cmd = accept & ~REG_SELECT & ~READ_WRITE_SEL;

  // instruction class from the highest set bit, lower bits ignored
  always_comb begin
    op = CLD_OP_NOP;
    if (byte_in[CLD_B_DDADDR]) begin
      op = CLD_OP_DDADDR;
    end else if (byte_in[CLD_B_CGADDR]) begin
      op = CLD_OP_CGADDR;
    end else if (byte_in[CLD_B_FUNC]) begin
      op = CLD_OP_FUNC;
    end else if (byte_in[CLD_B_SHIFT]) begin
      op = CLD_OP_SHIFT;
    end else if (byte_in[CLD_B_DISPCTL]) begin
      op = CLD_OP_DISPCTL;
    end else if (byte_in[CLD_B_ENTRY]) begin
      op = CLD_OP_ENTRY;
    end else if (byte_in[CLD_B_HOME]) begin
      op = CLD_OP_HOME;
    end else if (byte_in[CLD_B_CLEAR]) begin
      op = CLD_OP_CLEAR;
    end
  end

  // address stepping, glyph addresses wrap within six bits
  assign ac_fwd = r_ff.ac + CLD_ONE;
  assign ac_back = r_ff.ac - CLD_ONE;
  assign ac_step = (r_ff.incr_decr ? ac_fwd : ac_back)
                   & (r_ff.cg_sel ? CLD_CG_MASK : CLD_CLR_LAST);

  // byte presented to the host on a read
  always_comb begin
    if (~REG_SELECT) begin
      rd_byte = {busy, r_ff.ac};
    end else if (r_ff.cg_sel) begin
      rd_byte = cg_rdata;
    end else begin
      rd_byte = dd_rdata;
    end
  end

  // execution time per instruction
  always_comb begin
    tmr_start = acc_wr | acc_rd | (acc_cmd & op != CLD_OP_NOP);
    if (acc_cmd & (op == CLD_OP_CLEAR | op == CLD_OP_HOME)) begin
      tmr_ticks = CLD_TK_LONG;
    end else if (acc_wr | acc_rd) begin
      tmr_ticks = CLD_TK_DATA;
    end else begin
      tmr_ticks = CLD_TK_CMD;
    end
  end

  // next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.e_d = ENABLE;
    // nibble pairing follows every falling edge in 4-bit mode
    if (fall & ~r_ff.bus_width) begin
      if (r_ff.nib == CLD_NIB_HI) begin
        nxt_r.nib = CLD_NIB_LO;
        nxt_r.hi_nib = DB_IN[7:4];
      end else begin
        nxt_r.nib = CLD_NIB_HI;
      end
    end
    // read data, nibble-split in 4-bit mode, low lines zero
    if (r_ff.bus_width) begin
      nxt_r.dout = rd_byte;
    end else if (r_ff.nib == CLD_NIB_HI) begin
      nxt_r.dout = {rd_byte[7:4], CLD_NIB_PAD};
    end else begin
      nxt_r.dout = {rd_byte[3:0], CLD_NIB_PAD};
    end
    // background fill of display memory during clear
    if (r_ff.clearing) begin
      nxt_r.clr_idx = r_ff.clr_idx + CLD_ONE;
      if (r_ff.clr_idx == CLD_CLR_LAST) begin
        nxt_r.clearing = 1'b0;
      end
    end
    // data transfers step the counter, writes may shift the display
    if (acc_wr | acc_rd) begin
      nxt_r.ac = ac_step;
    end
    if (acc_wr & ~r_ff.cg_sel & r_ff.auto_shift) begin
      nxt_r.shift_off = r_ff.incr_decr ? r_ff.shift_off + CLD_ONE
                                       : r_ff.shift_off - CLD_ONE;
    end
    // instruction execution
    if (acc_cmd) begin
      unique case (op)
        CLD_OP_NOP: begin
        end
        CLD_OP_CLEAR: begin
          nxt_r.clearing = 1'b1;
          nxt_r.clr_idx = CLD_AC_ZERO;
          nxt_r.ac = CLD_AC_ZERO;
          nxt_r.cg_sel = 1'b0;
          nxt_r.shift_off = CLD_AC_ZERO;
          nxt_r.incr_decr = 1'b1;
        end
        CLD_OP_HOME: begin
          nxt_r.ac = CLD_AC_ZERO;
          nxt_r.cg_sel = 1'b0;
          nxt_r.shift_off = CLD_AC_ZERO;
        end
        CLD_OP_ENTRY: begin
          nxt_r.incr_decr = byte_in[CLD_B_INC];
          nxt_r.auto_shift = byte_in[CLD_B_ASH];
        end
        CLD_OP_DISPCTL: begin
          nxt_r.display_on = byte_in[CLD_B_DON];
          nxt_r.cursor_on = byte_in[CLD_B_CUR];
          nxt_r.blink_on = byte_in[CLD_B_BLK];
        end
        CLD_OP_SHIFT: begin
          if (~byte_in[CLD_B_STGT]) begin
            nxt_r.ac = byte_in[CLD_B_SDIR] ? ac_fwd : ac_back;
          end else begin
            // display moves left: window start advances
            nxt_r.shift_off = byte_in[CLD_B_SDIR]
                              ? r_ff.shift_off - CLD_ONE
                              : r_ff.shift_off + CLD_ONE;
          end
        end
        CLD_OP_FUNC: begin
          nxt_r.bus_width = byte_in[CLD_B_BUSW];
          nxt_r.line_count = byte_in[CLD_B_LINES];
          nxt_r.font_size = byte_in[CLD_B_FONT];
          nxt_r.nib = CLD_NIB_HI;
        end
        CLD_OP_CGADDR: begin
          nxt_r.ac = byte_in[6:0] & CLD_CG_MASK;
          nxt_r.cg_sel = 1'b1;
        end
        CLD_OP_DDADDR: begin
          nxt_r.ac = byte_in[6:0];
          nxt_r.cg_sel = 1'b0;
        end
      endcase
    end
    // pixel drive view, character blanked while the display is off
    nxt_r.disp_char = r_ff.display_on ? dd_view : CLD_SPACE;
    nxt_r.glyph_row = cg_view;
  end

  // state register, reset leaves an 8-bit bus and increment mode
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      r_ff <= '0;
      r_ff.bus_width <= 1'b1;
      r_ff.incr_decr <= 1'b1;
      r_ff.disp_char <= CLD_SPACE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // memory write steering, the fill owns the port during clear
  assign dd_we = r_ff.clearing | (acc_wr & ~r_ff.cg_sel);
  assign cg_we = acc_wr & r_ff.cg_sel;
  assign dd_waddr = r_ff.clearing ? r_ff.clr_idx : r_ff.ac;
  assign dd_wdata = r_ff.clearing ? CLD_SPACE : byte_in;
  assign view_addr = DISP_COL + r_ff.shift_off;

  // display memory
  cld_char_ram #(
    .AW(CLD_AW_DD)
  ) u_dd_ram (
    .clk(SYS_CLK),
    .we(dd_we),
    .waddr(dd_waddr),
    .wdata(dd_wdata),
    .raddr_a(r_ff.ac),
    .rdata_a(dd_rdata),
    .raddr_b(view_addr),
    .rdata_b(dd_view)
  );

  // glyph memory
  cld_char_ram #(
    .AW(CLD_AW_CG)
  ) u_cg_ram (
    .clk(SYS_CLK),
    .we(cg_we),
    .waddr(r_ff.ac[5:0]),
    .wdata(byte_in),
    .raddr_a(r_ff.ac[5:0]),
    .rdata_a(cg_rdata),
    .raddr_b(GLYPH_ADDR),
    .rdata_b(cg_view)
  );

  // execution timer on the internal oscillator
  cld_busy_timer #(
    .OSC_DIV(OSC_DIV)
  ) u_timer (
    .clk(SYS_CLK),
    .rst(RST),
    .start(tmr_start),
    .ticks(tmr_ticks),
    .busy(busy)
  );

  // outputs
  assign DB_OUT = r_ff.dout;
  assign DB_OE = ENABLE & READ_WRITE_SEL;
  assign BUSY_FLAG = busy;
  assign ADDR_COUNTER = r_ff.ac;
  assign GLYPH_SEL = r_ff.cg_sel;
  assign INCR_DECR = r_ff.incr_decr;
  assign AUTO_SHIFT = r_ff.auto_shift;
  assign DISPLAY_ON = r_ff.display_on;
  assign CURSOR_ON = r_ff.cursor_on;
  assign BLINK_ON = r_ff.blink_on;
  assign BUS_WIDTH = r_ff.bus_width;
  assign LINE_COUNT = r_ff.line_count;
  assign FONT_SIZE = r_ff.font_size;
  assign DISP_SHIFT = r_ff.shift_off;
  assign DISP_CHAR = r_ff.disp_char;
  assign GLYPH_ROW = r_ff.glyph_row;

  // checks on the executed behaviour
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  chk_busy_start: assert property (tmr_start |=> busy ##1 busy)
    else $error("busy did not rise after an accepted transfer");
  chk_clear_state: assert property (acc_cmd && op == CLD_OP_CLEAR
    |=> r_ff.ac == CLD_AC_ZERO && r_ff.incr_decr && r_ff.clearing)
    else $error("clear did not reset address and direction");
  chk_home_state: assert property (acc_cmd && op == CLD_OP_HOME
    |=> r_ff.ac == CLD_AC_ZERO && r_ff.shift_off == CLD_AC_ZERO)
    else $error("home did not zero address and shift");
  chk_entry_bits: assert property (acc_cmd && op == CLD_OP_ENTRY
    |=> r_ff.incr_decr == $past(byte_in[CLD_B_INC])
        && r_ff.auto_shift == $past(byte_in[CLD_B_ASH]))
    else $error("entry mode bits not stored");
  chk_dispctl_bits: assert property (acc_cmd && op == CLD_OP_DISPCTL
    |=> {DISPLAY_ON, CURSOR_ON, BLINK_ON} == $past(byte_in[2:0]))
    else $error("display control bits not stored");
  chk_func_bits: assert property (acc_cmd && op == CLD_OP_FUNC
    |=> {BUS_WIDTH, LINE_COUNT, FONT_SIZE} == $past(byte_in[4:2]))
    else $error("function set bits not stored");
  chk_glyph_addr: assert property (acc_cmd && op == CLD_OP_CGADDR
    |=> GLYPH_SEL && ADDR_COUNTER == {1'b0, $past(byte_in[5:0])})
    else $error("glyph address not loaded");
  chk_disp_addr: assert property (acc_cmd && op == CLD_OP_DDADDR
    |=> !GLYPH_SEL && ADDR_COUNTER == $past(byte_in[6:0]))
    else $error("display address not loaded");
  chk_step_up: assert property ((acc_wr || acc_rd) && r_ff.incr_decr
    && !r_ff.cg_sel |=> ADDR_COUNTER == $past(ADDR_COUNTER) + CLD_ONE)
    else $error("address did not step up after access");
  chk_status_busy: assert property (busy && $past(busy) && status_rd
    && $past(status_rd) && r_ff.bus_width |-> DB_OUT[7])
    else $error("busy flag not visible on status read");
  chk_no_shift_rd: assert property (acc_rd
    |=> r_ff.shift_off == $past(r_ff.shift_off))
    else $error("display shifted on a read");
  chk_blank_off: assert property (!r_ff.display_on
    |=> DISP_CHAR == CLD_SPACE)
    else $error("display not blanked while off");
  chk_refuse_busy: assert property (busy && xfer_done
    |=> r_ff.ac == $past(r_ff.ac)
        && r_ff.display_on == $past(r_ff.display_on))
    else $error("transfer changed state while busy");
endmodule // cld_char_lcd_decoder

// *** common/cld_pkg.sv ***
// Purpose: shared constants and types of the character display decoder
// Assumes: system clock 250 MHz, internal oscillator 270 kHz
// Notes:   execution times are kept in microseconds and converted to ticks
package cld_pkg;
  // clock and oscillator rates
  localparam int CLD_CLK_HZ = 250_000_000;
  localparam int CLD_OSC_HZ = 270_000;
  localparam int CLD_OSC_DIV = CLD_CLK_HZ / CLD_OSC_HZ;
  localparam int CLD_US_PER_S = 1_000_000;
  // execution times in microseconds
  localparam int CLD_T_LONG_US = 1530;
  localparam int CLD_T_CMD_US = 39;
  localparam int CLD_T_DATA_US = 43;
  // execution times in oscillator ticks, rounded up
  localparam logic [8:0] CLD_TK_LONG = 9'((CLD_T_LONG_US * CLD_OSC_HZ
    + CLD_US_PER_S - 1) / CLD_US_PER_S);
  localparam logic [8:0] CLD_TK_CMD = 9'((CLD_T_CMD_US * CLD_OSC_HZ
    + CLD_US_PER_S - 1) / CLD_US_PER_S);
  localparam logic [8:0] CLD_TK_DATA = 9'((CLD_T_DATA_US * CLD_OSC_HZ
    + CLD_US_PER_S - 1) / CLD_US_PER_S);
  // class bits, highest set bit names the instruction
  localparam int CLD_B_DDADDR = 7;
  localparam int CLD_B_CGADDR = 6;
  localparam int CLD_B_FUNC = 5;
  localparam int CLD_B_SHIFT = 4;
  localparam int CLD_B_DISPCTL = 3;
  localparam int CLD_B_ENTRY = 2;
  localparam int CLD_B_HOME = 1;
  localparam int CLD_B_CLEAR = 0;
  // field positions inside instructions
  localparam int CLD_B_BUSW = 4;
  localparam int CLD_B_LINES = 3;
  localparam int CLD_B_FONT = 2;
  localparam int CLD_B_STGT = 3;
  localparam int CLD_B_SDIR = 2;
  localparam int CLD_B_DON = 2;
  localparam int CLD_B_CUR = 1;
  localparam int CLD_B_BLK = 0;
  localparam int CLD_B_INC = 1;
  localparam int CLD_B_ASH = 0;
  // memory geometry and fixed values
  localparam int CLD_AW_DD = 7;
  localparam int CLD_AW_CG = 6;
  localparam logic [7:0] CLD_SPACE = 8'h20;
  localparam logic [6:0] CLD_AC_ZERO = 7'h00;
  localparam logic [6:0] CLD_CG_MASK = 7'h3F;
  localparam logic [6:0] CLD_CLR_LAST = 7'h7F;
  localparam logic [6:0] CLD_ONE = 7'h01;
  localparam logic [3:0] CLD_NIB_PAD = 4'h0;
  // nibble phase of the 4-bit bus
  typedef enum logic [0:0] {
    CLD_NIB_HI = 1'b0,
    CLD_NIB_LO = 1'b1
  } cld_nib_e;
  // decoded instruction class
  typedef enum logic [3:0] {
    CLD_OP_NOP = 4'h0,
    CLD_OP_CLEAR = 4'h1,
    CLD_OP_HOME = 4'h2,
    CLD_OP_ENTRY = 4'h3,
    CLD_OP_DISPCTL = 4'h4,
    CLD_OP_SHIFT = 4'h5,
    CLD_OP_FUNC = 4'h6,
    CLD_OP_CGADDR = 4'h7,
    CLD_OP_DDADDR = 4'h8
  } cld_op_e;
endpackage

// *** design/cld_busy_timer.sv ***
// Purpose: internal oscillator divider and execution countdown
// Assumes: start is a one-cycle pulse with the tick count
// Notes:   busy stays high until the last oscillator tick has passed
`timescale 1ns/1ps
module cld_busy_timer import cld_pkg::*; #(
  parameter int OSC_DIV = CLD_OSC_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // start of an execution
  input wire logic start,
  input wire logic [8:0] ticks,
  // execution in progress
  output logic busy
);
  localparam logic [9:0] DIV_LAST = 10'(OSC_DIV - 1);

  typedef struct packed {
    logic [9:0] div;
    logic [8:0] left;
  } cld_tmr_s;

  cld_tmr_s r_ff;
  cld_tmr_s nxt_r;

  // divider restarts on each start so the first tick is a full period
  always_comb begin
    nxt_r = r_ff;
    if (start) begin
      nxt_r.div = DIV_LAST;
      nxt_r.left = ticks;
    end else if (r_ff.left != '0) begin
      if (r_ff.div == '0) begin
        nxt_r.div = DIV_LAST;
        nxt_r.left = r_ff.left - 9'h001;
      end else begin
        nxt_r.div = r_ff.div - 10'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign busy = (r_ff.left != '0);
endmodule // cld_busy_timer

// *** design/cld_char_ram.sv ***
// Purpose: byte memory with one write port and two read ports
// Assumes: reads are combinational, writes on the clock edge
// Notes:   contents are not reset, as in a real character memory
`timescale 1ns/1ps
module cld_char_ram import cld_pkg::*; #(
  parameter int AW = CLD_AW_DD
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);
  logic [7:0] mem [2**AW];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read ports
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // cld_char_ram

// *** tb/cld_host_model.sv ***
// Purpose: host processor model that drives the parallel display bus
// Assumes: a transfer is taken on the enable fall, a byte or a nibble
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
module cld_host_model #(
  parameter int OSC_DIV = 4
) (
  // clock
  input wire logic clk,
  // host bus
  output logic rs,
  output logic rw,
  output logic en,
  output logic [7:0] db,
  input wire logic [7:0] dq
);
  bit four_bit = 1'b0;
  // bus idle at time zero
  initial begin
    rs = 1'b0;
    rw = 1'b0;
    en = 1'b0;
    db = 8'h00;
  end
  // one enable pulse, read data taken at the edge before the fall
  task automatic pulse(input logic r, w, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk);
    rs <= r;
    rw <= w;
    db <= w ? ~db : d;
    en <= 1'b1;
    repeat (2) @(posedge clk);
    q = dq;
    en <= 1'b0;
    @(posedge clk);
  endtask
  // one byte, as two upper-line nibbles on the narrow bus
  task automatic xfer(input logic r, w, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (four_bit) begin
      pulse(r, w, d, h);
      pulse(r, w, {d[3:0], 4'h0}, l);
      q = {h[7:4], l[7:4]};
    end else begin
      pulse(r, w, d, q);
    end
    if (!r && !w && d[7:5] == 3'h1) begin
      four_bit = !d[4];
    end
  endtask
  // poll the busy flag, then allow half an oscillator period plus one clock
  task automatic wait_idle(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 3000 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
    repeat (OSC_DIV / 2 + 1) @(posedge clk);
  endtask
endmodule // cld_host_model

// *** tb/cld_char_lcd_decoder_tb_top.sv ***
// Purpose: self-checking bench of the character display decoder
// Assumes: the host model obeys busy except in the refused test; oscillator divider cut to 4
// Notes:   expectations come from a bench copy of RAM and mode state
`timescale 1ns/1ps
module cld_char_lcd_decoder_tb_top import cld_pkg::*; ;
  localparam int D = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] disp_col = 7'h00;
  logic [5:0] glyph_addr = 6'h00;
  wire rs, rw, en, busy, gsel, db_oe;
  wire [7:0] db_in, db_out, modes, disp_char, glyph_row;
  wire [6:0] ac_o, sh_o;
  logic [7:0] em = 8'h84;
  logic [6:0] ac = 7'h00;
  logic [6:0] sh = 7'h00;
  logic gs = 1'b0;
  logic [7:0] dd [128];
  logic [7:0] cg [64];
  logic [15:0] lf = 16'h0060;
  int n_checks = 0;
  int miscompares = 0;
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  // host partner and device
  cld_host_model #(.OSC_DIV(D)) i_host (.clk(sys_clk), .rs(rs), .rw(rw),
    .en(en), .db(db_in), .dq(db_out));
  cld_char_lcd_decoder #(.OSC_DIV(D)) i_dut (.SYS_CLK(sys_clk), .RST(rst),
    .REG_SELECT(rs), .READ_WRITE_SEL(rw), .ENABLE(en), .DB_IN(db_in),
    .DB_OUT(db_out), .DB_OE(db_oe), .BUSY_FLAG(busy), .ADDR_COUNTER(ac_o),
    .GLYPH_SEL(gsel), .INCR_DECR(modes[7]), .AUTO_SHIFT(modes[6]),
    .DISPLAY_ON(modes[5]), .CURSOR_ON(modes[4]), .BLINK_ON(modes[3]),
    .BUS_WIDTH(modes[2]), .LINE_COUNT(modes[1]), .FONT_SIZE(modes[0]),
    .DISP_SHIFT(sh_o), .DISP_COL(disp_col), .DISP_CHAR(disp_char),
    .GLYPH_ADDR(glyph_addr), .GLYPH_ROW(glyph_row));
  // device drives the data lines only during a read strobe
  always @(negedge sys_clk) begin
    if (en) check(16'(db_oe), 16'(rw), "drive");
  end
  // shift register source of random values
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  // next address after a RAM access
  function automatic logic [6:0] nxt(input logic [6:0] a);
    logic [6:0] n;
    n = em[7] ? a + 7'h01 : a - 7'h01;
    return gs ? (n & 7'h3F) : n;
  endfunction
  task automatic check(input logic [15:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("MISMATCH t=%0t wait bound used up", $time);
    tally_and_finish();
  endtask
  task automatic chk_state();
    @(negedge sys_clk);
    check(16'(modes), 16'(em), "mode bits");
    check(16'(ac_o), 16'(ac), "address");
    check(16'(sh_o), 16'(sh), "shift");
    check(16'(gsel), 16'(gs), "ram select");
  endtask
  // wait idle, issue one transfer, time the busy span it starts
  task automatic run(input logic r, w, input logic [7:0] d, input int tk,
                     output logic [7:0] q);
    bit ok;
    int n;
    n = 0;
    i_host.wait_idle(ok);
    if (!ok) hang();
    i_host.xfer(r, w, d, q);
    for (int i = 0; i < 2000; i++) begin
      @(negedge sys_clk);
      if (busy === 1'b1) n++;
      else if (n > 0 || i > 3) break;
    end
    if (busy !== 1'b0) hang();
    ok = tk == 0 ? n == 0 : n > tk * D - D && n <= tk * D + D;
    check(16'(ok), 16'h0001, "busy span");
  endtask
  // instruction with the bench's view of its effect
  task automatic ins(input logic [7:0] d);
    logic [7:0] q;
    int tk;
    tk = CLD_TK_CMD;
    casez (d)
      8'b1???????: begin
        ac = d[6:0];
        gs = 1'b0;
      end
      8'b01??????: begin
        ac = {1'b0, d[5:0]};
        gs = 1'b1;
      end
      8'b001?????: em[2:0] = d[4:2];
      8'b0001????: begin
        if (d[3]) sh = d[2] ? sh - 7'h01 : sh + 7'h01;
        else ac = d[2] ? ac + 7'h01 : ac - 7'h01;
      end
      8'b00001???: em[5:3] = d[2:0];
      8'b000001??: em[7:6] = d[1:0];
      8'b0000001?: begin
        ac = 7'h00;
        sh = 7'h00;
        gs = 1'b0;
        tk = CLD_TK_LONG;
      end
      8'h00: tk = 0;
      default: begin
        ac = 7'h00;
        sh = 7'h00;
        gs = 1'b0;
        em[7] = 1'b1;
        tk = CLD_TK_LONG;
        foreach (dd[i]) dd[i] = CLD_SPACE;
      end
    endcase
    run(1'b0, 1'b0, d, tk, q);
    chk_state();
  endtask
  // data write or read of the selected RAM
  task automatic dat(input logic w, input logic [7:0] d);
    logic [7:0] q;
    logic [7:0] e;
    e = gs ? cg[ac[5:0]] : dd[ac];
    run(1'b1, ~w, d, CLD_TK_DATA, q);
    if (w) begin
      if (gs) cg[ac[5:0]] = d;
      else dd[ac] = d;
      if (!gs && em[6]) sh = em[7] ? sh + 7'h01 : sh - 7'h01;
    end else begin
      check(16'(q), 16'(e), "read data");
    end
    ac = nxt(ac);
    chk_state();
  endtask
  task automatic stat();
    logic [7:0] q;
    run(1'b0, 1'b1, 8'h00, 0, q);
    check(16'(q), 16'({1'b0, ac}), "status");
  endtask
  // pixel side views of both RAMs
  task automatic view(input logic [6:0] c, input logic [5:0] g);
    @(posedge sys_clk);
    disp_col <= c;
    glyph_addr <= g;
    repeat (2) @(negedge sys_clk);
    check(16'(disp_char), 16'(em[5] ? dd[7'(c + sh)] : 8'h20), "char");
    check(16'(glyph_row), 16'(cg[g]), "glyph row");
  endtask
  // main sequence
  initial begin
    logic [7:0] g;
    logic [7:0] q;
    bit ok;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    chk_state();
    ins(8'h01);
    for (int k = 0; k < 4; k++) ins(8'h30 | 8'(k << 2) | (rnd() & 8'h03));
    for (int k = 0; k < 4; k++) ins(8'h04 | 8'(k));
    for (int k = 0; k < 8; k++) ins(8'h08 | 8'(k));
    stat();
    ins(8'h00);
    $display("test modes done");
    for (int k = 0; k < 2; k++) begin
      ins(8'h80 | rnd());
      ins(8'h07);
      repeat (2) dat(1'b1, rnd());
      ins(8'h05);
      repeat (2) dat(1'b1, rnd());
      ins(8'h04);
      repeat (3) dat(1'b0, 8'h00);
      ins(8'h0C);
      view(7'(ac - 7'h01), 6'h00);
      ins(8'h08);
    end
    ins(8'h0F);
    $display("test display ram done");
    g = rnd() & 8'h3F;
    ins(8'h07);
    ins(8'h40 | g);
    repeat (3) dat(1'b1, rnd());
    ins(8'h40 | g);
    repeat (3) dat(1'b0, 8'h00);
    ins(8'h7F);
    repeat (2) dat(1'b1, rnd());
    view(7'(rnd()), 6'h3F);
    $display("test glyph ram done");
    ins(8'h80 | rnd());
    for (int k = 0; k < 4; k++) ins(8'h10 | 8'(k << 2) | (rnd() & 8'h03));
    ins(8'h02 | (rnd() & 8'h01));
    stat();
    $display("test shift and home done");
    ins(8'h20 | (rnd() & 8'h0C));
    ins(8'h80 | rnd());
    ins(8'h06);
    repeat (2) dat(1'b1, rnd());
    ins(8'h04);
    repeat (3) dat(1'b0, 8'h00);
    stat();
    ins(8'h30 | (rnd() & 8'h0C));
    $display("test narrow bus done");
    i_host.wait_idle(ok);
    i_host.xfer(1'b0, 1'b0, 8'h0C, q);
    em[5:3] = 3'h4;
    i_host.xfer(1'b0, 1'b1, 8'h00, q);
    check(16'(q), 16'({1'b1, ac}), "busy status");
    i_host.xfer(1'b1, 1'b0, rnd(), q);
    i_host.xfer(1'b0, 1'b0, 8'h08, q);
    i_host.wait_idle(ok);
    chk_state();
    dat(1'b0, 8'h00);
    $display("test refused done");
    tally_and_finish();
  end
endmodule // cld_char_lcd_decoder_tb_top
